// ===== dv/prs_button_model.sv
// Purpose: Pushbutton contact model with 0, 2 or 4 bounce toggles on each change
// Assumes: i_press high means the button is held down
// Notes: Bounce lasts at most 4 clock cycles, under the 12-cycle option E deglitch but over the 3-cycle option A copy
`timescale 1ns/1ps
`default_nettype none
module prs_button_model (
    input wire logic i_ref_clk,
    input wire logic i_press,
    output logic o_button
);
    int bn = 0;
    initial
    begin
        o_button = 1'b1;
    end
    always @(posedge i_ref_clk)
    begin
        if (bn > 0)
        begin
            bn <= bn - 1;
            o_button <= #1 ~o_button;
        end
        else if (o_button !== !i_press)
        begin
            // Even toggle count so the contact settles at the new level
            bn <= 2 * ($urandom % 3);
            o_button <= #1 !i_press;
        end
    end
endmodule
`default_nettype wire

// ===== dv/prs_supervisor_test.sv
// Purpose: Self-checking bench for the pushbutton reset supervisor
// Assumes: Short tick and deglitch counts, option E, small resistor;
//          option A copy with a tick every cycle
// Notes: Timing windows allow a tick of slack plus contact bounce
`timescale 1ns/1ps
`default_nettype none
module prs_supervisor_test;
    localparam int TC = 4;
    localparam int DG = 3;
    localparam int TO = 9;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic good = 1'b1;
    logic pa = 1'b0, pb = 1'b0, pc = 1'b0, pd = 1'b0;
    logic ba, bb, bc, bd, rs, ss, rd, sd, ro, so;
    logic [1:0] sel = 2'h0;
    logic [9:0] kohm = 10'h001;
    int cyc = 0, fs = 0, fd = 0, miscompares = 0, total_checks = 0;
    always #12.5 ref_clk = ~ref_clk;
    prs_button_model ma (.i_ref_clk(ref_clk), .i_press(pa), .o_button(ba));
    prs_button_model mb (.i_ref_clk(ref_clk), .i_press(pb), .o_button(bb));
    prs_button_model mc (.i_ref_clk(ref_clk), .i_press(pc), .o_button(bc));
    prs_button_model md (.i_ref_clk(ref_clk), .i_press(pd), .o_button(bd));
    // Option A at one tick per cycle keeps its seconds-long delays short
    prs_supervisor #(.OPT(prs_pkg::PRS_OPT_A), .TIMEOUT_TICKS(TO),
        .TICK_CYC(1), .DG_TICKS(DG)) opt_u (
        .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_supply_good(good),
        .i_button_in_a(bd), .i_button_in_b(1'b1), .i_sel_level(sel),
        .i_sel_kohm(kohm), .o_reset_n(ro), .o_soft_reset_n(so));
    prs_supervisor #(.OPT(prs_pkg::PRS_OPT_E), .TIMEOUT_TICKS(TO),
        .TICK_CYC(TC), .DG_TICKS(DG)) dut_u (
        .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_supply_good(good),
        .i_button_in_a(ba), .i_button_in_b(1'b1), .i_sel_level(sel),
        .i_sel_kohm(kohm), .o_reset_n(rs), .o_soft_reset_n(ss));
    prs_supervisor #(.DUAL(1'b1), .OPT(prs_pkg::PRS_OPT_E),
        .TIMEOUT_TICKS(TO), .TICK_CYC(TC), .DG_TICKS(DG)) dual_u (
        .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_supply_good(good),
        .i_button_in_a(bb), .i_button_in_b(bc), .i_sel_level(sel),
        .i_sel_kohm(kohm), .o_reset_n(rd), .o_soft_reset_n(sd));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if ($fell(rs))
            fs <= fs + 1;
        if ($fell(rd))
            fd <= fd + 1;
        if (cyc == 90000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string w, input int lo, input int hi,
        input int g);
        total_checks++;
        if (g < lo || g > hi)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", w, lo,
                hi, g);
        end
    endtask
    task automatic chkl(input string w, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", w, e, g);
        end
    endtask
    task automatic wait_rs(input logic v, output int n);
        n = 0;
        while (rs !== v && n < 20000)
        begin
            step(1);
            n++;
        end
    endtask
    // Deglitch plus setup, in clock cycles
    function automatic int fire_cyc(input int k);
        return (DG + k * 500) * TC;
    endfunction
    // Option A setup delay in ticks: 0.5, 1 or 2 s
    function automatic int su_opt_a(input logic [1:0] s);
        return (s == 2'h0) ? 5000 : (s == 2'h1) ? 10000 : 20000;
    endfunction
    initial
    begin
        int n, f, t, fc, fa;
        logic [1:0] s0;
        t = $urandom(32'h16748658);
        kohm = 10'h001 + 10'($urandom % 2);
        sel = 2'($urandom % 3);
        fc = fire_cyc(kohm);
        step(20);
        reset_n = 1'b1;
        chkl("reset after release", 1'b0, rs);
        wait_rs(1'b1, n);
        chk("startup timeout", TO * TC - TC, TO * TC + 3 * TC, n);
        good = 1'b0;
        step(1);
        chkl("supply loss", 1'b0, rs);
        step(10 + $urandom % 30);
        chkl("supply still low", 1'b0, rs);
        good = 1'b1;
        wait_rs(1'b1, n);
        chk("supply timeout", TO * TC - TC, TO * TC + 3 * TC, n);
        f = fs;
        pa = 1'b1;
        step(TC);
        chkl("soft before deglitch", 1'b1, ss);
        step(fc / 4 + $urandom % (fc / 2));
        chkl("soft while held", 1'b0, ss);
        pa = 1'b0;
        step(fc);
        chk("aborted press", f, f, fs);
        chkl("soft after release", 1'b1, ss);
        pa = 1'b1;
        wait_rs(1'b0, n);
        chk("setup delay", fc - 2 * TC, fc + 4 * TC, n);
        wait_rs(1'b1, n);
        chk("pulse length", TO * TC - TC, TO * TC + 2 * TC, n);
        // Release blip far shorter than the debounce must not rearm
        pa = 1'b0;
        step(1);
        pa = 1'b1;
        step(2 * fc);
        chk("one pulse per hold", f + 1, f + 1, fs);
        pa = 1'b0;
        step(DG * TC + 4 * TC);
        pa = 1'b1;
        step(fc + TO * TC + 8 * TC);
        chk("rearmed pulse", f + 2, f + 2, fs);
        pa = 1'b0;
        f = fd;
        pb = 1'b1;
        step(fc + 8 * TC);
        chk("one button of two", f, f, fd);
        pc = 1'b1;
        step(fc + 8 * TC);
        chk("both buttons", f + 1, f + 1, fd);
        chkl("dual soft idle", 1'b1, sd);
        // Select moved after reset must not alter the sampled delay
        s0 = sel;
        sel = 2'((sel + 2'h1) % 3);
        fa = su_opt_a(s0) + DG;
        pd = 1'b1;
        n = 0;
        while (ro !== 1'b0 && n < 30000)
        begin
            step(1);
            n++;
        end
        chk("option A delay", fa - 2, fa + 10, n);
        chkl("option A soft", 1'b0, so);
        n = 0;
        while (ro !== 1'b1 && n < 100)
        begin
            step(1);
            n++;
        end
        chk("option A pulse", TO - 1, TO + 2, n);
        pd = 1'b0;
        give_verdict();
    end
endmodule
`default_nettype wire

// ===== src/prs_deglitch.sv
// Purpose: Deglitch one button input: falling edge delayed, release debounced
// Assumes: i_tick is a one-cycle 0.1 ms enable
// Notes: Output high means released
`include "prs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module prs_deglitch #(
    parameter int DG_TICKS = `PRS_DEGLITCH_TICKS
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_tick,
    input wire logic i_button,
    output logic o_level
);
    logic [15:0] cnt_r;
    logic lvl_r;
    wire differs = i_button != lvl_r;
    // Both directions need a steady 20 ms; release bounce restarts the count
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            cnt_r <= 16'h0;
            lvl_r <= 1'b1;
        end
        else if (!differs)
            cnt_r <= 16'h0;
        else if (i_tick)
        begin
            if (cnt_r == 16'(DG_TICKS - 1))
            begin
                lvl_r <= i_button;
                cnt_r <= 16'h0;
            end
            else
                cnt_r <= cnt_r + 16'h1;
        end
    end
    assign o_level = lvl_r;
endmodule
`default_nettype wire

// ===== src/prs_pkg.sv
// Purpose: Types for the reset supervisor
// Assumes: Nothing
// Notes: Delay options and reset output states as enums
package prs_pkg;
    typedef enum logic [1:0] {
        // One bit flips on hold to wait, wait to run and run to wait
        PRS_ST_HOLD = 2'h0,
        PRS_ST_WAIT = 2'h1,
        PRS_ST_RUN = 2'h3
    } prs_state_t;
    typedef enum logic [2:0] {
        PRS_OPT_A = 3'h0,
        PRS_OPT_B = 3'h1,
        PRS_OPT_C = 3'h2,
        PRS_OPT_D = 3'h3,
        PRS_OPT_E = 3'h4
    } prs_opt_t;
endpackage

// ===== src/prs_regs.svh
// Purpose: Timing constants and select encodings for the reset supervisor
// Assumes: 40 MHz reference clock, one 0.1 ms tick enable
// Notes: Deglitch, setup delay and timeout all counted in 0.1 ms ticks
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH
`define PRS_CLK_HZ 40000000
`define PRS_TICK_US 100
`define PRS_TICK_CYC ((`PRS_CLK_HZ / 1000000) * `PRS_TICK_US)
`define PRS_DEGLITCH_MS 20
`define PRS_DEGLITCH_TICKS (`PRS_DEGLITCH_MS * 10)
`define PRS_SEL_GND 2'h0
`define PRS_SEL_OPEN 2'h1
`define PRS_SEL_VCC 2'h2
`define PRS_SEL_RES 2'h3
`define PRS_RES_DIV 20
`define PRS_TICKS_PER_S 10000
`define PRS_TIMEOUT_TICKS 9
// Setup delays per option and select level, in 0.1 ms ticks
`define PRS_SU_A_GND 24'h1388
`define PRS_SU_A_OPEN 24'h2710
`define PRS_SU_A_VCC 24'h4e20
`define PRS_SU_B_GND 24'h7530
`define PRS_SU_B_OPEN 24'h9c40
`define PRS_SU_B_VCC 24'hc350
`define PRS_SU_C_GND 24'hea60
`define PRS_SU_C_OPEN 24'h13880
`define PRS_SU_C_VCC 24'h186a0
`define PRS_SU_D_GND 24'h1fbd0
`define PRS_SU_D_OPEN 24'h249f0
`define PRS_SU_D_VCC 24'h29810
`endif

// ===== src/prs_supervisor.sv
// Purpose: Pushbutton reset supervisor with supply-good reset
// Assumes: Inputs synchronous to i_ref_clk; supply-good already clean
// Notes: Setup delay fixed at the first cycle after reset release
`include "prs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module prs_supervisor #(
    parameter bit DUAL = 1'b0,
    parameter prs_pkg::prs_opt_t OPT = prs_pkg::PRS_OPT_A,
    // Timeout in 0.1 ms ticks; 9 = 0.9 ms (suffix A), 73728 = suffix S
    parameter int TIMEOUT_TICKS = `PRS_TIMEOUT_TICKS,
    parameter int TICK_CYC = `PRS_TICK_CYC,
    parameter int DG_TICKS = `PRS_DEGLITCH_TICKS
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_supply_good,
    input wire logic i_button_in_a,
    input wire logic i_button_in_b,
    input wire logic [1:0] i_sel_level,
    input wire logic [9:0] i_sel_kohm,
    output logic o_reset_n,
    output logic o_soft_reset_n
);
    // Counter widths: 17-bit timeout, 16-bit divider and deglitch
    generate
        if (TIMEOUT_TICKS < 1 || TIMEOUT_TICKS > 131071 || TICK_CYC < 1
            || TICK_CYC > 65536 || DG_TICKS < 1 || DG_TICKS > 65535)
        begin : gen_bad_param
            $error("prs_supervisor: unsupported parameter values");
        end
    endgenerate

    // Free timebase: one-cycle tick every 0.1 ms
    logic [15:0] div_r;
    logic tick_r;
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            div_r <= 16'h0;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= div_r == 16'(TICK_CYC - 1);
            div_r <= (div_r == 16'(TICK_CYC - 1)) ? 16'h0 : div_r + 16'h1;
        end
    end

    logic lvl_a, lvl_b;
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_dg
            logic lvl;
            prs_deglitch #(.DG_TICKS(DG_TICKS)) u_dg (
                .i_ref_clk(i_ref_clk),
                .i_reset_n(i_reset_n),
                .i_tick(tick_r),
                .i_button(g == 0 ? i_button_in_a : (DUAL ? i_button_in_b
                                                         : 1'b0)),
                .o_level(lvl)
            );
        end
    endgenerate
    assign lvl_a = gen_dg[0].lvl;
    assign lvl_b = gen_dg[1].lvl;

    // Setup delay in 0.1 ms ticks from option and select level, or from i_sel_kohm for option E
    function automatic logic [23:0] setup_ticks(input logic [1:0] lv,
                                               input logic [9:0] kohm);
        logic [23:0] t;
        t = 24'h0;
        case (OPT)
            prs_pkg::PRS_OPT_A: t = (lv == `PRS_SEL_GND) ? `PRS_SU_A_GND :
                (lv == `PRS_SEL_OPEN) ? `PRS_SU_A_OPEN : `PRS_SU_A_VCC;
            prs_pkg::PRS_OPT_B: t = (lv == `PRS_SEL_GND) ? `PRS_SU_B_GND :
                (lv == `PRS_SEL_OPEN) ? `PRS_SU_B_OPEN : `PRS_SU_B_VCC;
            prs_pkg::PRS_OPT_C: t = (lv == `PRS_SEL_GND) ? `PRS_SU_C_GND :
                (lv == `PRS_SEL_OPEN) ? `PRS_SU_C_OPEN : `PRS_SU_C_VCC;
            prs_pkg::PRS_OPT_D: t = (lv == `PRS_SEL_GND) ? `PRS_SU_D_GND :
                (lv == `PRS_SEL_OPEN) ? `PRS_SU_D_OPEN : `PRS_SU_D_VCC;
            // kohm/20 s = kohm*500 ticks of 0.1 ms
            prs_pkg::PRS_OPT_E: t = 24'(kohm)
                * 24'(`PRS_TICKS_PER_S / `PRS_RES_DIV);
            default: t = `PRS_SU_A_GND;
        endcase
        return (t == 24'h0) ? 24'h1 : t;
    endfunction

    logic [23:0] su_lim_r;
    logic su_taken_r;
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            su_lim_r <= 24'h1;
            su_taken_r <= 1'b0;
        end
        else if (!su_taken_r)
        begin
            su_lim_r <= setup_ticks(i_sel_level,
                i_sel_kohm);
            su_taken_r <= 1'b1;
        end
    end

    // Pressed: the active buttons all recognised low
    wire pressed = DUAL ? (!lvl_a && !lvl_b) : !lvl_a;
    logic [23:0] su_cnt_r;
    logic armed_r, fire_r;
    wire su_done = su_taken_r && pressed && armed_r && tick_r
        && su_cnt_r == su_lim_r - 24'h1;
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            su_cnt_r <= 24'h0;
            armed_r <= 1'b1;
            fire_r <= 1'b0;
        end
        else
        begin
            fire_r <= su_done;
            if (!pressed)
            begin
                su_cnt_r <= 24'h0;
                armed_r <= 1'b1;
            end
            else if (su_done)
            begin
                su_cnt_r <= 24'h0;
                armed_r <= 1'b0;
            end
            else if (armed_r && tick_r)
                su_cnt_r <= su_cnt_r + 24'h1;
        end
    end

    // Reset output state machine
    prs_pkg::prs_state_t st_r, st_nxt;
    logic [16:0] to_cnt_r;
    wire to_done = tick_r && to_cnt_r == 17'(TIMEOUT_TICKS - 1);
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            prs_pkg::PRS_ST_HOLD:
                if (i_supply_good)
                    st_nxt = prs_pkg::PRS_ST_WAIT;
            prs_pkg::PRS_ST_WAIT:
                if (!i_supply_good)
                    st_nxt = prs_pkg::PRS_ST_HOLD;
                else if (to_done)
                    st_nxt = prs_pkg::PRS_ST_RUN;
            prs_pkg::PRS_ST_RUN:
                if (!i_supply_good)
                    st_nxt = prs_pkg::PRS_ST_HOLD;
                else if (fire_r)
                    st_nxt = prs_pkg::PRS_ST_WAIT;
            default: st_nxt = prs_pkg::PRS_ST_HOLD;
        endcase
    end

    logic rst_n_r, soft_n_r;
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            st_r <= prs_pkg::PRS_ST_HOLD;
            to_cnt_r <= 17'h0;
            rst_n_r <= 1'b0;
            soft_n_r <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
            if (st_nxt != prs_pkg::PRS_ST_WAIT
                || st_r != prs_pkg::PRS_ST_WAIT)
                to_cnt_r <= 17'h0;
            else if (tick_r)
                to_cnt_r <= to_cnt_r + 17'h1;
            rst_n_r <= st_nxt == prs_pkg::PRS_ST_RUN;
            soft_n_r <= DUAL ? 1'b1 : lvl_a;
        end
    end
    assign o_reset_n = rst_n_r;
    assign o_soft_reset_n = soft_n_r;

    // Supply drop forces reset low on the next edge
    sequence supply_drop_s;
        !i_supply_good;
    endsequence
    supply_low_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        supply_drop_s |=> !o_reset_n)
        else $error("reset not asserted on bad supply");
    hold_after_good_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(i_supply_good) |=> !o_reset_n [*2])
        else $error("reset released too early after supply return");
    fire_pulls_low_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        fire_r && o_reset_n |=> !o_reset_n)
        else $error("button condition did not pulse reset");
    abort_on_release_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !pressed |=> su_cnt_r == 24'h0 && !fire_r)
        else $error("setup timing not aborted by release");
    // The fire decision used the levels of the cycle before fire_r
    dual_both_low_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        fire_r |-> (DUAL ? !($past(lvl_a) || $past(lvl_b)) : !$past(lvl_a)))
        else $error("reset fired without all buttons held");
    // A release recognised on the fire tick may rearm at once
    single_pulse_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        fire_r |=> !fire_r && (!armed_r || !$past(pressed)))
        else $error("more than one pulse per press");
    soft_mirror_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !DUAL && $changed(lvl_a) |=> o_soft_reset_n == $past(lvl_a))
        else $error("soft reset does not follow button");
    setup_once_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        su_taken_r |=> $stable(su_lim_r))
        else $error("setup delay changed after sampling");
endmodule
`default_nettype wire
